// ==== rtl/rtc_cfg.svh ====
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
`define ADDR_SECONDS 8'h00
`define ADDR_MINUTES 8'h01
`define ADDR_HOURS 8'h02
`define ADDR_DAY 8'h03
`define ADDR_MONTH 8'h04
`define ADDR_YEAR 8'h05
`define ADDR_WEEKDAY 8'h06
`define ADDR_TENTHS 8'h07
`define ADDR_DC_STATUS 8'h08
`define ADDR_AC_STATUS 8'h09
`define ADDR_LINE_FAIL_COUNT 8'h0a
`define ADDR_EVENT_COUNT 8'h0b
`define ADDR_EVENT_INDEX 8'h0f
`define LAST_TIME_ADDR 8'h07
`define DC_STATUS_RESET 8'h01
`define SUMMER_FORCE_VALUE 8'hf0
`define COUNT_MAX 8'hff
`define BIT_BACKUP 7
`define BIT_SUMMER 6
`define BIT_ALARM_ONE 5
`define BIT_ALARM_ZERO 4
`define BIT_SUPPLY_LOW 3
`define BIT_BACKUP_FIRST 2
`define BIT_BACKUP_SECOND 1
`define BIT_POWER_LOSS 0
`define BIT_CRYSTAL_STOP 4
`define BIT_LINE_FAIL 1
`define BIT_LINE_READY 0
`define TICK_PERIOD_NS 100000000
`define CLOCK_PERIOD_NS 8
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLOCK_PERIOD_NS)
`define READY_UNIT_CYCLES (`TICK_CYCLES * 10)
`endif

// ==== rtl/rtc_pkg.sv ====
package rtc_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {src_crystal, src_line} source_t;
endpackage : rtc_pkg

// ==== rtl/rtc_tick_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface rtc_tick_if;
   logic align;
   logic run;
   logic tick;
   modport divider (input align, input run, output tick);
   modport user (output align, output run, input tick);
endinterface : rtc_tick_if
`default_nettype wire

// ==== rtl/rtc_tenth_divider.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rtc_cfg.svh"
module rtc_tenth_divider #(
   parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   rtc_tick_if.divider tk
);
   logic [31:0] count;
   wire logic at_end = (count == TICK_CYCLES - 1);
   // Restart on alignment so the tick phase follows the host write
   always_ff @(posedge clock) begin
      if (reset || tk.align || !tk.run) begin
         count <= 32'h0;
      end else if (at_end) begin
         count <= 32'h0;
      end else begin
         count <= count + 32'h1;
      end
   end
   assign tk.tick = tk.run && !tk.align && at_end;
endmodule : rtc_tenth_divider
`default_nettype wire

// ==== rtl/rtc_time_status_counters.sv ====
// Function
// - Time and calendar held in BCD ranges
// - Tenths read-only, 0-9, cleared by time writes
// - Weekday three bits, 0 to 6, reset 0
// - Hour format bit selects 24h or 12h
// - February 29 when year divisible by four
// - No century exception applied
// - Backup flag needs backup mode and enable
// - Summer flag follows changes, cleared when disabled
// - Writing f0 to status forces summer flag
// - Alarm flags set by match, cleared by write of 0 or auto-clear
// - Match during status read survives auto-clear
// - Supply low flag from brownout comparator
// - Backup low flags from two comparators
// - Power loss flag set after total loss
// - First time write clears power loss flag
// - Crystal stop flag follows oscillator state
// - Line fail flag follows qualification
// - Ready line times clock, else crystal
// - Ready rises after delay, drops at once
// - Line fail counter counts switches, saturates
// - Event counter counts events, saturates
// - Zero to event count clears stamps too
// - Auto-clear of flags after status read stop
// - Counting starts at write stop, tick aligned
`timescale 1ns/100ps
`default_nettype none
`include "rtc_cfg.svh"
module rtc_time_status_counters #(
   parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
   parameter int unsigned READY_UNIT_CYCLES = `READY_UNIT_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic write_strobe,
   input wire logic [7:0] write_addr,
   input wire rtc_pkg::byte_t write_data,
   input wire logic [7:0] read_addr,
   output rtc_pkg::byte_t read_data,
   input wire logic dc_read_active,
   input wire logic dc_read_stop,
   input wire logic write_stop,
   input wire logic clock_write_enable,
   input wire logic auto_clear_on_read,
   input wire logic serial_in_backup_enable,
   input wire logic summer_time_enable,
   input wire logic summer_forward,
   input wire logic summer_reverse,
   input wire logic on_backup,
   input wire logic total_loss_powerup,
   input wire logic alarm_zero_match,
   input wire logic alarm_one_match,
   input wire logic supply_below_trip,
   input wire logic backup_below_first,
   input wire logic backup_below_second,
   input wire logic crystal_stopped,
   input wire logic line_qualified,
   input wire logic line_tenth_tick,
   input wire logic [1:0] line_ready_delay,
   input wire logic event_detected,
   output logic clear_event_stamps,
   output logic line_ready_flag,
   output logic line_fail_flag,
   output logic crystal_stop_flag
);
   import rtc_pkg::*;

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction : bcd_inc

   function automatic logic [7:0] days_in(input logic [4:0] m, input logic [7:0] y);
      logic leap;
      // Two-digit count divisible by four; 2000 and 2100 both leap
      leap = ((y[4] ? 1'b1 : 1'b0) ^ y[1]) == 1'b0 && y[0] == 1'b0;
      case (m)
         5'h02: days_in = leap ? 8'h29 : 8'h28;
         5'h04, 5'h06, 5'h09, 5'h11: days_in = 8'h30;
         default: days_in = 8'h31;
      endcase
   endfunction : days_in

   logic [3:0] tenths;
   logic [6:0] seconds_count;
   logic [6:0] minutes_count;
   logic [5:0] hours_count;
   logic hour_format_24;
   logic [5:0] day_of_month;
   logic [4:0] cal_mth;
   logic [7:0] year_count;
   logic [2:0] weekday;
   logic running;
   logic summer_time_applied;
   logic alarm_zero_flag;
   logic alarm_one_flag;
   logic supply_low_flag;
   logic backup_low_first_flag;
   logic backup_low_second_flag;
   logic total_power_loss_flag;
   logic [7:0] line_fail_counter;
   logic [7:0] event_counter;
   logic [31:0] ready_wait;
   source_t source;

   rtc_tick_if tk ();
   rtc_tenth_divider #(.TICK_CYCLES(TICK_CYCLES)) divider (
      .clock(clock),
      .reset(reset),
      .tk(tk)
   );

   wire logic time_write = write_strobe && write_addr <= `LAST_TIME_ADDR
      && write_addr != `ADDR_TENTHS;
   wire logic dc_write = write_strobe && write_addr == `ADDR_DC_STATUS;
   wire logic start_align = write_stop && clock_write_enable;
   assign tk.align = start_align;
   assign tk.run = running;
   wire logic tenth_tick = (source == src_line) ? (running && line_tenth_tick) : tk.tick;

   wire logic sec_tick = tenth_tick && tenths == 4'h9;
   wire logic min_tick = sec_tick && seconds_count == 7'h59;
   wire logic hour_tick = min_tick && minutes_count == 7'h59;
   wire logic [4:0] hour_bcd = hours_count[4:0];
   wire logic day_tick = hour_tick && (hour_format_24 ? (hours_count == 6'h23)
      : (hours_count == 6'h31));
   wire logic month_tick = day_tick && {2'b00, day_of_month} == days_in(cal_mth, year_count);
   wire logic year_tick = month_tick && cal_mth == 5'h12;
   wire logic auto_clear = auto_clear_on_read && dc_read_stop;
   wire byte_t sec_step = bcd_inc({1'b0, seconds_count});
   wire byte_t min_step = bcd_inc({1'b0, minutes_count});
   wire byte_t day_step = bcd_inc({2'b00, day_of_month});
   wire byte_t month_step = bcd_inc({3'b000, cal_mth});

   // Tenths and seconds
   always_ff @(posedge clock) begin
      if (reset || time_write) begin
         tenths <= 4'h0;
      end else if (tenth_tick) begin
         tenths <= (tenths == 4'h9) ? 4'h0 : tenths + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         running <= 1'b0;
      end else if (start_align) begin
         running <= 1'b1;
      end else if (!clock_write_enable) begin
         running <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         seconds_count <= 7'h00;
         minutes_count <= 7'h00;
      end else if (time_write && write_addr == `ADDR_SECONDS) begin
         seconds_count <= write_data[6:0];
      end else if (time_write && write_addr == `ADDR_MINUTES) begin
         minutes_count <= write_data[6:0];
      end else if (sec_tick) begin
         seconds_count <= (seconds_count == 7'h59) ? 7'h00 : sec_step[6:0];
         if (min_tick) begin
            minutes_count <= (minutes_count == 7'h59) ? 7'h00 : min_step[6:0];
         end
      end
   end

   // Hours: 12-hour mode keeps pm in bit 5 and counts 12,1..11
   wire byte_t hour_step = bcd_inc({3'b000, hour_bcd});
   wire byte_t hour24_step = bcd_inc({2'b00, hours_count});
   wire logic [4:0] hour_inc = hour_step[4:0];
   logic [5:0] next_hours;
   always_comb begin
      if (hour_format_24) begin
         next_hours = (hours_count == 6'h23) ? 6'h00 : hour24_step[5:0];
      end else if (hour_bcd == 5'h12) begin
         next_hours = {hours_count[5], 5'h01};
      end else if (hour_bcd == 5'h11) begin
         next_hours = {~hours_count[5], 5'h12};
      end else begin
         next_hours = {hours_count[5], hour_inc};
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         hours_count <= 6'h00;
         hour_format_24 <= 1'b0;
      end else if (time_write && write_addr == `ADDR_HOURS) begin
         hours_count <= write_data[5:0];
         hour_format_24 <= write_data[7];
      end else if (hour_tick) begin
         hours_count <= next_hours;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         day_of_month <= 6'h01;
         weekday <= 3'h0;
      end else if (time_write && write_addr == `ADDR_DAY) begin
         day_of_month <= write_data[5:0];
      end else if (time_write && write_addr == `ADDR_WEEKDAY) begin
         weekday <= write_data[2:0];
      end else if (day_tick) begin
         day_of_month <= month_tick ? 6'h01 : day_step[5:0];
         weekday <= (weekday == 3'h6) ? 3'h0 : weekday + 3'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         cal_mth <= 5'h01;
         year_count <= 8'h00;
      end else if (time_write && write_addr == `ADDR_MONTH) begin
         cal_mth <= write_data[4:0];
      end else if (time_write && write_addr == `ADDR_YEAR) begin
         year_count <= write_data;
      end else if (month_tick) begin
         cal_mth <= year_tick ? 5'h01 : month_step[4:0];
         if (year_tick) begin
            year_count <= (year_count == 8'h99) ? 8'h00 : bcd_inc(year_count);
         end
      end
   end

   // Status flags: hardware set wins over clears, except that disable overrides the summer set
   always_ff @(posedge clock) begin
      if (reset) begin
         summer_time_applied <= 1'b0;
      end else if (!summer_time_enable) begin
         summer_time_applied <= 1'b0;
      end else if (dc_write && write_data == `SUMMER_FORCE_VALUE) begin
         summer_time_applied <= 1'b1;
      end else if (summer_forward) begin
         summer_time_applied <= 1'b1;
      end else if (summer_reverse) begin
         summer_time_applied <= 1'b0;
      end
   end

   // Matches seen during a read are kept past the auto-clear
   logic alarm_zero_held;
   logic alarm_one_held;
   always_ff @(posedge clock) begin
      if (reset || !dc_read_active) begin
         alarm_zero_held <= 1'b0;
         alarm_one_held <= 1'b0;
      end else begin
         alarm_zero_held <= alarm_zero_held || alarm_zero_match;
         alarm_one_held <= alarm_one_held || alarm_one_match;
      end
   end

   wire logic clear_zero = auto_clear || (dc_write && !write_data[`BIT_ALARM_ZERO]);
   wire logic clear_one = auto_clear || (dc_write && !write_data[`BIT_ALARM_ONE]);
   always_ff @(posedge clock) begin
      if (reset) begin
         alarm_zero_flag <= 1'b0;
         alarm_one_flag <= 1'b0;
      end else begin
         alarm_zero_flag <= alarm_zero_match || (alarm_zero_held && auto_clear)
            || (alarm_zero_flag && !clear_zero);
         alarm_one_flag <= alarm_one_match || (alarm_one_held && auto_clear)
            || (alarm_one_flag && !clear_one);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         supply_low_flag <= 1'b0;
         backup_low_first_flag <= 1'b0;
         backup_low_second_flag <= 1'b0;
      end else begin
         supply_low_flag <= supply_below_trip || (supply_low_flag && !auto_clear);
         backup_low_first_flag <= backup_below_first
            || (backup_low_first_flag && !auto_clear);
         backup_low_second_flag <= backup_below_second
            || (backup_low_second_flag && !auto_clear);
      end
   end

   wire byte_t dc_reset_value = `DC_STATUS_RESET;
   always_ff @(posedge clock) begin
      if (reset) begin
         total_power_loss_flag <= dc_reset_value[`BIT_POWER_LOSS];
      end else if (total_loss_powerup) begin
         total_power_loss_flag <= 1'b1;
      end else if (time_write) begin
         total_power_loss_flag <= 1'b0;
      end
   end

   // Line qualification, ready delay and source selection
   wire logic [31:0] ready_target = READY_UNIT_CYCLES * ({30'h0, line_ready_delay} + 32'h1);
   always_ff @(posedge clock) begin
      if (reset) begin
         line_fail_flag <= 1'b1;
         line_ready_flag <= 1'b0;
         ready_wait <= 32'h0;
         crystal_stop_flag <= 1'b0;
      end else begin
         line_fail_flag <= !line_qualified;
         crystal_stop_flag <= crystal_stopped;
         if (!line_qualified) begin
            line_ready_flag <= 1'b0;
            ready_wait <= 32'h0;
         end else if (!line_ready_flag) begin
            if (ready_wait >= ready_target - 32'h1) begin
               line_ready_flag <= 1'b1;
            end
            ready_wait <= ready_wait + 32'h1;
         end
      end
   end
   assign source = line_ready_flag ? src_line : src_crystal;

   wire logic switch_to_crystal = line_ready_flag && !line_qualified;
   always_ff @(posedge clock) begin
      if (reset) begin
         line_fail_counter <= 8'h00;
      end else if (switch_to_crystal && line_fail_counter != `COUNT_MAX) begin
         line_fail_counter <= line_fail_counter + 8'h01;
      end else if (write_strobe && write_addr == `ADDR_LINE_FAIL_COUNT
         && write_data == 8'h00) begin
         line_fail_counter <= 8'h00;
      end
   end

   wire logic event_clear = write_strobe && write_addr == `ADDR_EVENT_COUNT
      && write_data == 8'h00;
   always_ff @(posedge clock) begin
      if (reset) begin
         event_counter <= 8'h00;
         clear_event_stamps <= 1'b0;
      end else begin
         clear_event_stamps <= event_clear;
         if (event_detected && event_counter != `COUNT_MAX) begin
            event_counter <= event_counter + 8'h01;
         end else if (event_clear) begin
            event_counter <= 8'h00;
         end
      end
   end

   // Read mux
   wire logic backup_supply_flag = on_backup && serial_in_backup_enable;
   wire byte_t dc_status = {backup_supply_flag, summer_time_applied, alarm_one_flag,
      alarm_zero_flag, supply_low_flag, backup_low_first_flag, backup_low_second_flag,
      total_power_loss_flag};
   wire byte_t ac_status = {3'b000, crystal_stop_flag, 2'b00, line_fail_flag, line_ready_flag};
   byte_t next_read;
   always_comb begin
      case (read_addr)
         `ADDR_SECONDS: next_read = {1'b0, seconds_count};
         `ADDR_MINUTES: next_read = {1'b0, minutes_count};
         `ADDR_HOURS: next_read = {hour_format_24, 1'b0, hours_count};
         `ADDR_DAY: next_read = {2'b00, day_of_month};
         `ADDR_MONTH: next_read = {3'b000, cal_mth};
         `ADDR_YEAR: next_read = year_count;
         `ADDR_WEEKDAY: next_read = {5'h00, weekday};
         `ADDR_TENTHS: next_read = {4'h0, tenths};
         `ADDR_DC_STATUS: next_read = dc_status;
         `ADDR_AC_STATUS: next_read = ac_status;
         `ADDR_LINE_FAIL_COUNT: next_read = line_fail_counter;
         `ADDR_EVENT_COUNT: next_read = event_counter;
         default: next_read = 8'h00;
      endcase
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         read_data <= 8'h00;
      end else begin
         read_data <= next_read;
      end
   end

   tenths_range_a: assert property (@(posedge clock) disable iff (reset)
      tenths <= 4'h9) else $error("tenths out of range");
   tenths_write_a: assert property (@(posedge clock) disable iff (reset)
      time_write |=> tenths == 4'h0) else $error("tenths not cleared");
   weekday_range_a: assert property (@(posedge clock) disable iff (reset)
      weekday <= 3'h6) else $error("weekday out of range");
   backup_flag_a: assert property (@(posedge clock) disable iff (reset)
      dc_status[`BIT_BACKUP] == (on_backup && serial_in_backup_enable))
      else $error("backup flag wrong");
   summer_off_a: assert property (@(posedge clock) disable iff (reset)
      !summer_time_enable |=> !summer_time_applied) else $error("summer not cleared");
   alarm_set_a: assert property (@(posedge clock) disable iff (reset)
      alarm_zero_match |=> alarm_zero_flag) else $error("alarm match lost");
   ready_drop_a: assert property (@(posedge clock) disable iff (reset)
      !line_qualified |=> !line_ready_flag) else $error("ready not dropped");
   count_sat_a: assert property (@(posedge clock) disable iff (reset)
      event_counter == 8'hff && !event_clear |=> event_counter == 8'hff)
      else $error("event counter wrapped");
   loss_clear_a: assert property (@(posedge clock) disable iff (reset)
      time_write && !total_loss_powerup |=> !total_power_loss_flag)
      else $error("loss flag kept");
endmodule : rtc_time_status_counters
`default_nettype wire

// ==== bench/rtc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtc_host_model (
   input wire logic clock,
   input wire rtc_pkg::byte_t read_data,
   output logic write_strobe,
   output logic [7:0] write_addr,
   output rtc_pkg::byte_t write_data,
   output logic [7:0] read_addr,
   output logic dc_read_active,
   output logic dc_read_stop,
   output logic write_stop
);
   import rtc_pkg::*;
   initial begin
      {write_strobe, dc_read_active, dc_read_stop, write_stop} = 4'h0;
      write_addr = 8'h00;
      write_data = 8'h00;
      read_addr = 8'h00;
   end
   task automatic wr(input byte_t a, input byte_t d);
      @(posedge clock);
      write_strobe <= 1'b1;
      write_addr <= a;
      write_data <= d;
      @(posedge clock);
      write_strobe <= 1'b0;
      // Released data shows the inverse so a stale byte is never taken
      write_data <= ~d;
   endtask : wr
   // Valid write ended by a stop condition
   task automatic stop();
      @(posedge clock);
      write_stop <= 1'b1;
      @(posedge clock);
      write_stop <= 1'b0;
   endtask : stop
   task automatic rd(input byte_t a, output byte_t d);
      @(posedge clock);
      read_addr <= a;
      repeat (2) @(posedge clock);
      #1 d = read_data;
   endtask : rd
   // Status read framed by active level and closing stop pulse
   task automatic dc_rd(output byte_t d);
      @(posedge clock);
      dc_read_active <= 1'b1;
      read_addr <= 8'h08;
      repeat (2) @(posedge clock);
      #1 d = read_data;
      @(posedge clock);
      dc_read_active <= 1'b0;
      dc_read_stop <= 1'b1;
      @(posedge clock);
      dc_read_stop <= 1'b0;
   endtask : dc_rd
endmodule : rtc_host_model
`default_nettype wire

// ==== bench/rtc_time_status_counters_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtc_time_status_counters_bench;
   import rtc_pkg::*;
   localparam int az = 0, a1 = 1, sf = 2, sr = 3, tl = 4, ev = 5, lt = 6, sl = 7, bf = 8, bs = 9;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [9:0] pulses;
   logic [1:0] line_ready_delay;
   logic clock_write_enable, auto_clear_on_read, serial_in_backup_enable, summer_time_enable;
   logic on_backup, crystal_stopped, line_qualified;
   logic write_strobe, dc_read_active, dc_read_stop, write_stop;
   logic [7:0] write_addr, read_addr;
   byte_t write_data, read_data;
   logic clear_event_stamps, line_ready_flag, line_fail_flag, crystal_stop_flag;
   int n_errors = 0;
   int samples_checked = 0;
   byte_t d;

   always #4 clock = ~clock;

   rtc_host_model host (.clock(clock), .read_data(read_data), .write_strobe(write_strobe),
      .write_addr(write_addr), .write_data(write_data), .read_addr(read_addr),
      .dc_read_active(dc_read_active), .dc_read_stop(dc_read_stop), .write_stop(write_stop));

   rtc_time_status_counters #(.TICK_CYCLES(10), .READY_UNIT_CYCLES(20)) DUT (
      .clock(clock), .reset(reset), .write_strobe(write_strobe), .write_addr(write_addr),
      .write_data(write_data), .read_addr(read_addr), .read_data(read_data),
      .dc_read_active(dc_read_active), .dc_read_stop(dc_read_stop), .write_stop(write_stop),
      .clock_write_enable(clock_write_enable), .auto_clear_on_read(auto_clear_on_read),
      .serial_in_backup_enable(serial_in_backup_enable),
      .summer_time_enable(summer_time_enable), .summer_forward(pulses[sf]),
      .summer_reverse(pulses[sr]), .on_backup(on_backup), .total_loss_powerup(pulses[tl]),
      .alarm_zero_match(pulses[az]), .alarm_one_match(pulses[a1]),
      .supply_below_trip(pulses[sl]), .backup_below_first(pulses[bf]),
      .backup_below_second(pulses[bs]), .crystal_stopped(crystal_stopped),
      .line_qualified(line_qualified), .line_tenth_tick(pulses[lt]),
      .line_ready_delay(line_ready_delay), .event_detected(pulses[ev]),
      .clear_event_stamps(clear_event_stamps), .line_ready_flag(line_ready_flag),
      .line_fail_flag(line_fail_flag), .crystal_stop_flag(crystal_stop_flag));

   task automatic check(input byte_t got, input byte_t exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic rdx(input byte_t a, input byte_t m, input byte_t exp);
      byte_t v;
      host.rd(a, v);
      check(v & m, exp);
   endtask : rdx

   task automatic pulse(input int k);
      @(posedge clock);
      pulses <= 10'h001 << k;
      @(posedge clock);
      pulses <= 10'h000;
   endtask : pulse

   task automatic close_out();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic reset_values();
      byte_t exp [12] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00,
                          8'h01, 8'h02, 8'h00, 8'h00};
      for (int i = 0; i < 12; i++) begin
         rdx(i[7:0], 8'hff, exp[i]);
      end
   endtask : reset_values

   task automatic power_loss();
      host.wr(8'h06, 8'h02);
      rdx(8'h08, 8'h01, 8'h00);
      pulse(tl);
      rdx(8'h08, 8'h01, 8'h01);
      host.wr(8'h05, 8'h00);
      rdx(8'h08, 8'h01, 8'h00);
   endtask : power_loss

   task automatic flags_and_auto_clear();
      for (int k = az; k <= bs; k++) begin
         if (k == az || k >= sl) begin
            pulse(k);
         end
      end
      rdx(8'h08, 8'hff, 8'h1e);
      host.wr(8'h08, 8'hff);
      rdx(8'h08, 8'h30, 8'h10);
      host.wr(8'h08, 8'h00);
      rdx(8'h08, 8'h30, 8'h00);
      pulse(az);
      @(posedge clock);
      auto_clear_on_read <= 1'b1;
      fork
         host.dc_rd(d);
         pulse(a1);
      join
      rdx(8'h08, 8'h3e, 8'h20);
      host.wr(8'h08, 8'h20);
      rdx(8'h08, 8'h20, 8'h20);
   endtask : flags_and_auto_clear

   task automatic summer_and_backup();
      @(posedge clock);
      summer_time_enable <= 1'b1;
      on_backup <= 1'b1;
      pulse(sf);
      rdx(8'h08, 8'hc0, 8'h40);
      pulse(sr);
      rdx(8'h08, 8'h40, 8'h00);
      host.wr(8'h08, 8'hf0);
      rdx(8'h08, 8'h40, 8'h40);
      @(posedge clock);
      summer_time_enable <= 1'b0;
      serial_in_backup_enable <= 1'b1;
      rdx(8'h08, 8'hc0, 8'h80);
      @(posedge clock);
      on_backup <= 1'b0;
      rdx(8'h08, 8'h80, 8'h00);
   endtask : summer_and_backup

   task automatic events();
      repeat (257) pulse(ev);
      rdx(8'h0b, 8'hff, 8'hff);
      host.wr(8'h0b, 8'h05);
      rdx(8'h0b, 8'hff, 8'hff);
      host.wr(8'h0b, 8'h00);
      #1 check({7'h00, clear_event_stamps}, 8'h01);
      @(posedge clock);
      #1 check({7'h00, clear_event_stamps}, 8'h00);
      rdx(8'h0b, 8'hff, 8'h00);
   endtask : events

   task automatic line_source();
      int n;
      @(posedge clock);
      line_ready_delay <= 2'h1;
      line_qualified <= 1'b1;
      repeat (2) @(posedge clock);
      #1 check({6'h00, line_fail_flag, line_ready_flag}, 8'h00);
      repeat (28) @(posedge clock);
      #1 check({7'h00, line_ready_flag}, 8'h00);
      n = 0;
      while (line_ready_flag !== 1'b1 && n < 15) begin
         @(posedge clock);
         #1 n++;
      end
      check({7'h00, line_ready_flag}, 8'h01);
      rdx(8'h09, 8'hff, 8'h01);
      @(posedge clock);
      line_qualified <= 1'b0;
      repeat (2) @(posedge clock);
      #1 check({6'h00, line_fail_flag, line_ready_flag}, 8'h02);
      rdx(8'h0a, 8'hff, 8'h01);
      host.wr(8'h0a, 8'h07);
      rdx(8'h0a, 8'hff, 8'h01);
      host.wr(8'h0a, 8'h00);
      rdx(8'h0a, 8'hff, 8'h00);
      @(posedge clock);
      crystal_stopped <= 1'b1;
      rdx(8'h09, 8'hff, 8'h12);
      check({7'h00, crystal_stop_flag}, 8'h01);
      @(posedge clock);
      crystal_stopped <= 1'b0;
      rdx(8'h09, 8'hff, 8'h02);
      check({7'h00, crystal_stop_flag}, 8'h00);
   endtask : line_source

   task automatic roll(input byte_t hr, dy, mo, yr, wd, ehr, edy, emo, eyr, ewd);
      host.wr(8'h00, 8'h59);
      host.wr(8'h01, 8'h59);
      host.wr(8'h02, hr);
      host.wr(8'h03, dy);
      host.wr(8'h04, mo);
      host.wr(8'h05, yr);
      host.wr(8'h06, wd);
      host.stop();
      // Ten crystal tenths at ten cycles each, tick aligned to the stop
      repeat (105) @(posedge clock);
      rdx(8'h00, 8'hff, 8'h00);
      rdx(8'h02, 8'hff, ehr);
      rdx(8'h03, 8'hff, edy);
      rdx(8'h04, 8'hff, emo);
      rdx(8'h05, 8'hff, eyr);
      rdx(8'h06, 8'hff, ewd);
   endtask : roll

   // Once the line is ready only line ticks may advance the tenths
   task automatic line_timebase();
      @(posedge clock);
      line_ready_delay <= 2'h0;
      line_qualified <= 1'b1;
      repeat (25) @(posedge clock);
      host.wr(8'h00, 8'h00);
      host.stop();
      repeat (30) @(posedge clock);
      rdx(8'h07, 8'hff, 8'h00);
      repeat (3) pulse(lt);
      rdx(8'h07, 8'hff, 8'h03);
   endtask : line_timebase

   task automatic tenths_clear();
      host.wr(8'h01, 8'h10);
      host.rd(8'h07, d);
      check({7'h00, d <= 8'h01}, 8'h01);
      host.wr(8'h07, 8'h09);
      host.rd(8'h07, d);
      check({7'h00, d <= 8'h01}, 8'h01);
   endtask : tenths_clear

   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      $display("ERROR %0t: run did not finish in time", $time);
      close_out();
   end

   initial begin
      pulses = 10'h000;
      line_ready_delay = 2'h0;
      {clock_write_enable, auto_clear_on_read, serial_in_backup_enable} = 3'h0;
      {summer_time_enable, on_backup, crystal_stopped, line_qualified} = 4'h0;
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      reset_values();
      power_loss();
      flags_and_auto_clear();
      summer_and_backup();
      events();
      line_source();
      @(posedge clock);
      clock_write_enable <= 1'b1;
      roll(8'h11, 8'h15, 8'h06, 8'h10, 8'h03, 8'h32, 8'h15, 8'h06, 8'h10, 8'h03);
      roll(8'h31, 8'h15, 8'h06, 8'h10, 8'h03, 8'h12, 8'h16, 8'h06, 8'h10, 8'h04);
      roll(8'ha3, 8'h28, 8'h02, 8'h04, 8'h06, 8'h80, 8'h29, 8'h02, 8'h04, 8'h00);
      roll(8'ha3, 8'h28, 8'h02, 8'h00, 8'h02, 8'h80, 8'h29, 8'h02, 8'h00, 8'h03);
      roll(8'ha3, 8'h28, 8'h02, 8'h03, 8'h02, 8'h80, 8'h01, 8'h03, 8'h03, 8'h03);
      roll(8'ha3, 8'h31, 8'h12, 8'h99, 8'h06, 8'h80, 8'h01, 8'h01, 8'h00, 8'h00);
      line_timebase();
      tenths_clear();
      close_out();
   end
endmodule : rtc_time_status_counters_bench
`default_nettype wire
